//--- shared/mac_mii_pkg.sv
// Shared constants and carriers for the MII and management port
package mac_mii_pkg;
   localparam int NIBBLE_W = 4;
   localparam int DIV_W = 8;
   localparam logic [5:0] MGMT_LAST_BIT = 6'h3f;
   localparam logic [5:0] MGMT_TA_BIT = 6'h2e;
   localparam logic [5:0] MGMT_DATA_BIT = 6'h30;
   localparam logic [31:0] MGMT_PREAMBLE = 32'hffffffff;
   localparam logic [1:0] MGMT_START = 2'h1;
   localparam logic [1:0] MGMT_OP_READ = 2'h2;
   localparam logic [1:0] MGMT_OP_WRITE = 2'h1;
   localparam logic [1:0] MGMT_TA_WRITE = 2'h2;
   localparam logic [7:0] MGMT_DIV_RESET = 8'h13;

   typedef struct packed {
      logic valid;
      logic last;
      logic [NIBBLE_W-1:0] nibble;
   } tx_req_s;

   typedef struct packed {
      logic valid;
      logic [NIBBLE_W-1:0] nibble;
      logic frame_end;
      logic frame_err;
   } rx_beat_s;

   typedef struct packed {
      logic write;
      logic [4:0] phy_addr;
      logic [4:0] reg_addr;
      logic [15:0] wdata;
   } mgmt_cmd_s;
endpackage

//--- rtl/mac_mii_port.sv
// MAC side of the MII data pins and the management serial master
`timescale 1ns/1ps
module mac_mii_port
   import mac_mii_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic clk_en,
   input wire logic full_duplex,
   input wire tx_req_s tx_req,
   output logic tx_ready,
   input wire logic phy_tx_clock,
   output logic [NIBBLE_W-1:0] tx_nibble,
   output logic tx_nibble_enable,
   output logic tx_error_out,
   input wire logic collision_in,
   input wire logic carrier_sense_in,
   output logic collision_seen,
   output logic carrier_seen,
   input wire logic phy_rx_clock,
   input wire logic [NIBBLE_W-1:0] rx_nibble,
   input wire logic rx_nibble_valid,
   input wire logic rx_error_in,
   output rx_beat_s rx_beat,
   input wire logic [DIV_W-1:0] mgmt_clock_divider,
   input wire logic mgmt_cmd_valid,
   input wire mgmt_cmd_s mgmt_cmd,
   output logic mgmt_cmd_ready,
   output logic [15:0] mgmt_rdata,
   output logic mgmt_done,
   output logic mgmt_clock_out,
   output logic mgmt_data_o,
   output logic mgmt_data_oe,
   input wire logic mgmt_data_i
);
   typedef enum logic {MGMT_IDLE, MGMT_RUN} mgmt_state_e;

   function automatic logic rising(input logic cur, input logic prev);
      return cur & ~prev;
   endfunction

   // Asynchronous status inputs
   logic col_s1_q, col_s2_q, crs_s1_q, crs_s2_q;
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         col_s1_q <= 1'b0;
         col_s2_q <= 1'b0;
         crs_s1_q <= 1'b0;
         crs_s2_q <= 1'b0;
      end else if (clk_en) begin
         col_s1_q <= collision_in;
         col_s2_q <= col_s1_q;
         crs_s1_q <= carrier_sense_in;
         crs_s2_q <= crs_s1_q;
      end
   end
   assign collision_seen = col_s2_q;
   assign carrier_seen = crs_s2_q;

   // Transmit path, stepped on each rising edge of the PHY transmit clock
   logic txc_prev_q, in_frame_q, tx_en_q;
   logic [NIBBLE_W-1:0] tx_nib_q;
   wire tx_edge = clk_en & rising(phy_tx_clock, txc_prev_q);
   // Full duplex: pause request; half duplex: defer while the medium is busy
   wire start_block = full_duplex ? col_s2_q : crs_s2_q;
   wire may_send = in_frame_q | ~start_block;
   wire tx_take = tx_edge & may_send & tx_req.valid;
   assign tx_ready = tx_edge & may_send;
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         txc_prev_q <= 1'b0;
         in_frame_q <= 1'b0;
         tx_en_q <= 1'b0;
         tx_nib_q <= '0;
      end else if (clk_en) begin
         txc_prev_q <= phy_tx_clock;
         if (tx_edge) begin
            tx_en_q <= tx_take;
            in_frame_q <= tx_take & ~tx_req.last;
            if (tx_take) begin
               tx_nib_q <= tx_req.nibble;
            end
         end
      end
   end
   assign tx_nibble = tx_nib_q;
   assign tx_nibble_enable = tx_en_q;
   assign tx_error_out = 1'b0;

   // Receive path, sampled on each rising edge of the PHY receive clock
   logic rxc_prev_q, rx_dv_prev_q, err_acc_q;
   rx_beat_s rx_q;
   wire rx_edge = clk_en & rising(phy_rx_clock, rxc_prev_q);
   wire rx_err_now = rx_nibble_valid & rx_error_in;
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rxc_prev_q <= 1'b0;
         rx_dv_prev_q <= 1'b0;
         err_acc_q <= 1'b0;
         rx_q <= '0;
      end else if (clk_en) begin
         rxc_prev_q <= phy_rx_clock;
         rx_q.valid <= 1'b0;
         rx_q.frame_end <= 1'b0;
         if (rx_edge) begin
            rx_dv_prev_q <= rx_nibble_valid;
            rx_q.valid <= rx_nibble_valid;
            if (rx_nibble_valid) begin
               rx_q.nibble <= rx_nibble;
               err_acc_q <= err_acc_q | rx_err_now;
            end else if (rx_dv_prev_q) begin
               rx_q.frame_end <= 1'b1;
               rx_q.frame_err <= err_acc_q;
               err_acc_q <= 1'b0;
            end
         end
      end
   end
   assign rx_beat = rx_q;

   // Management serial master
   mgmt_state_e state_q;
   logic [DIV_W-1:0] div_cnt_q;
   logic mdc_q, read_q, done_q;
   logic [5:0] bit_q;
   logic [63:0] shift_q;
   logic [15:0] rdata_q;
   wire busy = (state_q == MGMT_RUN);
   wire tick = busy & (div_cnt_q == mgmt_clock_divider);
   wire mgmt_start = clk_en & ~busy & mgmt_cmd_valid;
   wire in_read_data = read_q & (bit_q >= MGMT_DATA_BIT);
   wire sample_now = tick & ~mdc_q & read_q & (bit_q >= MGMT_DATA_BIT);
   wire frame_last = tick & mdc_q & (bit_q == MGMT_LAST_BIT);
   wire [63:0] frame_bits = {MGMT_PREAMBLE, MGMT_START,
      mgmt_cmd.write ? MGMT_OP_WRITE : MGMT_OP_READ, mgmt_cmd.phy_addr,
      mgmt_cmd.reg_addr, MGMT_TA_WRITE, mgmt_cmd.wdata};
   assign mgmt_cmd_ready = ~busy;
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state_q <= MGMT_IDLE;
         div_cnt_q <= '0;
         mdc_q <= 1'b0;
         read_q <= 1'b0;
         done_q <= 1'b0;
         bit_q <= '0;
         shift_q <= '0;
         rdata_q <= '0;
      end else if (clk_en) begin
         done_q <= 1'b0;
         div_cnt_q <= tick | ~busy ? '0 : div_cnt_q + 1'b1;
         case (state_q)
            MGMT_IDLE: begin
               if (mgmt_start) begin
                  state_q <= MGMT_RUN;
                  shift_q <= frame_bits;
                  read_q <= ~mgmt_cmd.write;
                  bit_q <= '0;
                  mdc_q <= 1'b0;
               end
            end
            MGMT_RUN: begin
               if (tick) begin
                  mdc_q <= ~mdc_q;
               end
               if (sample_now) begin
                  rdata_q <= {rdata_q[14:0], mgmt_data_i};
               end
               if (frame_last) begin
                  state_q <= MGMT_IDLE;
                  done_q <= 1'b1;
               end else if (tick & mdc_q) begin
                  bit_q <= bit_q + 6'h1;
                  shift_q <= {shift_q[62:0], 1'b0};
               end
            end
            default: state_q <= MGMT_IDLE;
         endcase
      end
   end
   assign mgmt_clock_out = mdc_q;
   assign mgmt_data_o = busy ? shift_q[63] : 1'b1;
   assign mgmt_data_oe = busy & ~in_read_data;
   assign mgmt_rdata = rdata_q;
   assign mgmt_done = done_q;

   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   a_tx_err_low: assert property (tx_error_out == 1'b0)
      else $error("transmit error output not low");
   a_tx_en_hold: assert property (clk_en && !tx_edge |=> $stable(tx_nibble_enable))
      else $error("transmit enable moved off a transmit clock edge");
   a_tx_nib_load: assert property (tx_take |=> tx_nibble == $past(tx_req.nibble))
      else $error("transmit nibble not the taken value");
   a_tx_flow_pause: assert property (tx_edge && full_duplex && col_s2_q && !in_frame_q
      |=> !tx_nibble_enable)
      else $error("frame started during flow control pause");
   a_tx_frame_runs: assert property (tx_edge && in_frame_q && tx_req.valid
      |=> tx_nibble_enable)
      else $error("running frame cut short");
   a_col_sync_delay: assert property (clk_en && $past(clk_en) && $past(clk_en, 2)
      |-> collision_seen == $past(collision_in, 2))
      else $error("collision not two stages late");
   a_rx_err_mark: assert property (rx_edge && rx_err_now |=> err_acc_q)
      else $error("receive error not recorded");
   a_rx_take_valid: assert property (rx_edge && !rx_nibble_valid |=> !rx_beat.valid)
      else $error("nibble taken without valid");
   a_mdio_release: assert property (busy && read_q && bit_q >= MGMT_DATA_BIT
      |-> !mgmt_data_oe)
      else $error("management pin driven during read data");
   a_mdio_drive_wr: assert property (busy && !read_q |-> mgmt_data_oe)
      else $error("management pin released during write");
   a_mdio_drive_hdr: assert property (busy && bit_q < MGMT_DATA_BIT |-> mgmt_data_oe)
      else $error("management pin released before the data bits");
   a_mgmt_preamble: assert property (mgmt_start |=> mgmt_data_o && mgmt_data_oe
      && !mgmt_clock_out)
      else $error("frame does not open with preamble");

   c_tx_frame: cover property (tx_take && tx_req.last);
   c_rx_err_frame: cover property (rx_beat.frame_end && rx_beat.frame_err);
   c_mgmt_read: cover property (mgmt_done && read_q);
   c_mgmt_write: cover property (mgmt_done && !read_q);
endmodule

//--- dv/phy_model.sv
// Behavioural PHY: continuous MII clocks and a management slave
`timescale 1ns/1ps
module phy_model
   import mac_mii_pkg::*;
#(
   parameter logic [15:0] READ_DATA = 16'h5a3c
)
(
   input wire logic clk,
   input wire logic mgmt_clock_out,
   input wire logic mgmt_data_o,
   input wire logic mgmt_data_oe,
   output logic mgmt_data_i,
   output logic phy_tx_clock,
   output logic phy_rx_clock
);
   logic [1:0] div_q = 2'h0;
   logic [1:0] op_q = 2'h0;
   logic drive_q = 1'b0;
   logic rd_q = 1'b1;
   int bit_q = 0;
   always @(posedge clk) div_q <= div_q + 2'h1;
   assign phy_tx_clock = div_q[1];
   assign phy_rx_clock = div_q[1];
   always @(posedge mgmt_data_oe) bit_q = 0;
   always @(posedge mgmt_clock_out) begin
      if (bit_q == 34 || bit_q == 35) op_q = {op_q[0], mgmt_data_i};
      bit_q = bit_q + 1;
   end
   // Drive turnaround low and the read data after falling clock edges
   always @(negedge mgmt_clock_out) begin
      drive_q = op_q == MGMT_OP_READ && bit_q >= 47 && bit_q <= 63;
      rd_q = (bit_q < 48) ? 1'b0 : READ_DATA[63 - bit_q];
   end
   // Pull-up holds the line high when nobody drives it
   assign mgmt_data_i = mgmt_data_oe ? mgmt_data_o : (drive_q ? rd_q : 1'b1);
endmodule

//--- dv/mac_mii_port_tb_top.sv
// Self-checking bench for the MII data pins and management master
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin failures++; \
   $display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end
module mac_mii_port_tb_top
   import mac_mii_pkg::*;
;
   localparam logic [15:0] RD = 16'h5a3c;
   logic clk = 1'b0, sys_rst = 1'b1, full_duplex = 1'b1, collision_in = 1'b0;
   logic carrier_sense_in = 1'b0, rx_nibble_valid = 1'b0, rx_error_in = 1'b0;
   logic mgmt_cmd_valid = 1'b0, txc_q = 1'b0, rxc_q = 1'b0, mcl_q = 1'b0, txerr = 1'b0;
   logic [3:0] rx_nibble = 4'h0, tx_nibble;
   logic [7:0] mgmt_clock_divider = 8'h01;
   tx_req_s tx_req = '0;
   mgmt_cmd_s mgmt_cmd = '0;
   rx_beat_s rx_beat;
   logic tx_ready, tx_nibble_enable, tx_error_out, collision_seen, carrier_seen, last_err;
   logic mgmt_cmd_ready, mgmt_done, mgmt_clock_out, mgmt_data_o, mgmt_data_oe, mgmt_data_i;
   logic phy_tx_clock, phy_rx_clock;
   logic [15:0] mgmt_rdata;
   logic [63:0] mg_bits, mg_oe;
   logic [3:0] tx_exp[$], tx_got[$], rx_exp[$], rx_got[$];
   int failures = 0, checks = 0, ends = 0, mg_cnt = 0, mg_per = 0, cyc = 0;
   logic [31:0] seed = 32'h31;
   mac_mii_port dut (.clk, .sys_rst, .clk_en(1'b1), .full_duplex, .tx_req, .tx_ready,
      .phy_tx_clock, .tx_nibble, .tx_nibble_enable, .tx_error_out, .collision_in,
      .carrier_sense_in, .collision_seen, .carrier_seen, .phy_rx_clock, .rx_nibble,
      .rx_nibble_valid, .rx_error_in, .rx_beat, .mgmt_clock_divider, .mgmt_cmd_valid,
      .mgmt_cmd, .mgmt_cmd_ready, .mgmt_rdata, .mgmt_done, .mgmt_clock_out, .mgmt_data_o,
      .mgmt_data_oe, .mgmt_data_i);
   phy_model #(.READ_DATA(RD)) phy (.clk, .mgmt_clock_out, .mgmt_data_o, .mgmt_data_oe,
      .mgmt_data_i, .phy_tx_clock, .phy_rx_clock);
   initial forever #5 clk = ~clk;
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   always @(posedge clk) begin
      if (phy_tx_clock && !txc_q && tx_nibble_enable) tx_got.push_back(tx_nibble);
      if (rx_beat.valid === 1'b1) rx_got.push_back(rx_beat.nibble);
      if (rx_beat.frame_end === 1'b1) begin
         ends++;
         last_err = rx_beat.frame_err;
      end
      if (tx_error_out !== 1'b0) txerr = 1'b1;
      cyc++;
      if (mgmt_clock_out && !mcl_q) begin
         mg_bits = {mg_bits[62:0], mgmt_data_i};
         mg_oe = {mg_oe[62:0], mgmt_data_oe};
         mg_cnt++;
         mg_per = cyc;
         cyc = 0;
      end
      txc_q <= phy_tx_clock;
      rxc_q <= phy_rx_clock;
      mcl_q <= mgmt_clock_out;
   end
   task automatic cmp_q(input logic [3:0] a[$], input logic [3:0] b[$]);
      `CHK(a.size(), b.size())
      foreach (b[i]) if (i < a.size()) `CHK(a[i], b[i])
   endtask
   task automatic send_tx(input int n);
      int w;
      for (int i = 0; i < n; i++) begin
         tx_exp.push_back(4'(rnd()));
         tx_req <= '{1'b1, i == n - 1, tx_exp[$]};
         w = 0;
         do @(negedge clk); while (tx_ready !== 1'b1 && ++w < 400);
         if (w >= 400) failures++;
         @(posedge clk);
      end
   endtask
   task automatic end_tx();
      tx_req <= '0;
      repeat (24) @(posedge clk);
      cmp_q(tx_got, tx_exp);
      tx_got.delete();
      tx_exp.delete();
   endtask
   task automatic blocked(input logic fd);
      full_duplex <= fd;
      collision_in <= fd;
      carrier_sense_in <= !fd;
      // Let the two-stage synchronisers settle before the first request
      repeat (3) @(posedge clk);
      fork
         send_tx(5);
         begin
            repeat (40) @(posedge clk);
            `CHK(tx_got.size(), 0)
            `CHK(fd ? collision_seen : carrier_seen, 1'b1)
            collision_in <= 1'b0;
            carrier_sense_in <= 1'b0;
         end
      join
      end_tx();
   endtask
   task automatic send_rx(input int n, input int e);
      for (int i = 0; i <= n; i++) begin
         do @(posedge clk); while (!(rxc_q === 1'b1 && phy_rx_clock === 1'b0));
         if (i < n) rx_exp.push_back(4'(rnd()));
         rx_nibble <= (i < n) ? rx_exp[$] : 4'h0;
         rx_nibble_valid <= i < n;
         rx_error_in <= i == e;
      end
      repeat (12) @(posedge clk);
      rx_error_in <= 1'b0;
      cmp_q(rx_got, rx_exp);
      `CHK(last_err, e < n)
      rx_got.delete();
      rx_exp.delete();
   endtask
   task automatic mgmt(input logic wr, input logic [7:0] div);
      logic [63:0] e;
      int w;
      mgmt_clock_divider <= div;
      mgmt_cmd <= '{wr, 5'(rnd()), 5'(rnd()), 16'(rnd())};
      mgmt_cmd_valid <= 1'b1;
      @(posedge clk);
      mgmt_cmd_valid <= 1'b0;
      mg_cnt = 0;
      @(negedge clk);
      `CHK(mgmt_cmd_ready, 1'b0)
      w = 0;
      do @(negedge clk); while (mgmt_done !== 1'b1 && ++w < 2000);
      if (w >= 2000) failures++;
      `CHK(mgmt_cmd_ready, 1'b1)
      e = {MGMT_PREAMBLE, MGMT_START, wr ? MGMT_OP_WRITE : MGMT_OP_READ, mgmt_cmd.phy_addr,
         mgmt_cmd.reg_addr, MGMT_TA_WRITE, wr ? mgmt_cmd.wdata : RD};
      `CHK(mg_bits, e)
      `CHK(mg_oe, wr ? {64{1'b1}} : {{48{1'b1}}, 16'h0})
      `CHK(mg_cnt, 64)
      `CHK(mg_per, 2 * (div + 1))
      if (!wr) `CHK(mgmt_rdata, RD)
      @(posedge clk);
   endtask
   task automatic test_done();
      $display("failures %0d checks %0d", failures, checks);
      if (failures == 0 && checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   initial begin
      #400000;
      failures++;
      test_done();
   end
   initial begin
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      blocked(1'b1);
      fork
         send_tx(12);
         begin
            repeat (20) @(posedge clk);
            collision_in <= 1'b1;
         end
      join
      end_tx();
      collision_in <= 1'b0;
      send_tx(1);
      send_tx(7);
      end_tx();
      blocked(1'b0);
      $display("transmit tests done, %0d checks", checks);
      send_rx(9, 3);
      send_rx(6, 6);
      `CHK(ends, 2)
      $display("receive tests done, %0d checks", checks);
      for (int i = 0; i < 4; i++) mgmt(i[0], 8'(i));
      $display("management tests done, %0d checks", checks);
      for (int i = 0; i < 3; i++) send_tx(2 + int'(rnd() % 6));
      end_tx();
      `CHK(txerr, 1'b0)
      $display("random transmit done, %0d checks", checks);
      test_done();
   end
endmodule
